// ---- hw/pci_hsk_pkg.sv ----
package pci_hsk_pkg;
    // published bus command encodings on c_be_n during the address phase
    localparam logic [3:0] CMD_CFG_READ = 4'ha;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
    // reset values of the pin drivers (deasserted, high)
    localparam logic RST_PIN = 1'b1;
    // depth of the pin input synchroniser
    localparam int SYNC_DEPTH = 3;

    typedef enum logic [1:0] {
        ROLE_IDLE = 2'b00,
        ROLE_INIT = 2'b01,
        ROLE_TARG = 2'b10
    } role_e;

    typedef enum logic [1:0] {
        TS_IDLE = 2'b00,
        TS_DATA = 2'b01,
        TS_STOP = 2'b10,
        TS_DONE = 2'b11
    } tstate_e;
endpackage : pci_hsk_pkg

// ---- hw/pci_hsk_stop_cfg.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// R1 - initiator holding ready high inserts a wait state in the data phase
// R2 - a data phase completes only on an edge with both ready lines low
// R3 - initiator ready is driven as initiator and sampled as target
// R4 - initiator ready floats when the device is not part of the transaction
// R5 - initiator ready changes and is sampled on rising clock edges only
// R6 - target stop high lets the initiator continue; stop low ends it
// R7 - as initiator, stop seen low ends the transaction next cycle
// R8 - as target, stop is asserted on configuration accesses after one word
// R9 - as target, stop also on initiator wait states, never otherwise
// R10 - stop floats when idle; input as initiator, output as target
// R11 - stop changes and is sampled on rising clock edges only
// R12 - selected configuration command asserts device select the clock after the filtered pins decode it
// R13 - host raises select in the address phase; sampled on rising edges
// R14 - configuration read and write codes follow the published encodings
module pci_hsk_stop_cfg (
    input wire logic clock,
    input wire logic arst_n,
    // initiator side request from the local master machine
    input wire logic mst_start,
    input wire logic mst_ready,
    input wire logic mst_last,
    output logic mst_done,
    output logic mst_xfer,
    output logic mst_stopped,
    // bus pins
    input wire logic frame_n_in,
    input wire logic [3:0] c_be_n_in,
    input wire logic idsel_in,
    input wire logic trdy_n_in,
    input wire logic irdy_n_in,
    output logic irdy_n_out,
    output logic irdy_n_oe,
    input wire logic stop_n_in,
    output logic stop_n_out,
    output logic stop_n_oe,
    output logic devsel_n_out,
    output logic devsel_n_oe,
    output logic trdy_n_out,
    output logic trdy_n_oe,
    // configuration access strobe toward the register block
    output logic cfg_access,
    output logic cfg_write
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages two and three agree
    // pin to decision takes four edges; stage one is read only by stage two
    localparam int NIN = 9;
    logic [NIN-1:0] pin_raw;
    logic [NIN-1:0] s1;
    logic [NIN-1:0] s2;
    logic [NIN-1:0] s3;
    logic [NIN-1:0] pin;
    assign pin_raw = {frame_n_in, c_be_n_in, idsel_in, trdy_n_in, irdy_n_in, stop_n_in};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
            pin <= '1;
        end else begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
            pin <= (s2 & s3) | (pin & (s2 ^ s3));
        end
    end
    wire frame_n = pin[8];
    wire [3:0] cbe_n = pin[7:4];
    wire idsel = pin[3];
    wire trdy_n = pin[2]; // [R5] [R11] [R13]
    wire irdy_n = pin[1];
    wire stop_n = pin[0];

    ////////////////////////////////////////////////////////////////////////////
    pci_hsk_pkg::role_e role;
    pci_hsk_pkg::role_e next_role;
    pci_hsk_pkg::tstate_e ts;
    pci_hsk_pkg::tstate_e next_ts;
    logic frame_q;
    logic is_write;

    wire frame_fall = frame_q & ~frame_n;
    wire is_cfg_rd = (cbe_n == pci_hsk_pkg::CMD_CFG_READ); // [R14]
    wire is_cfg_wr = (cbe_n == pci_hsk_pkg::CMD_CFG_WRITE); // [R14]
    wire cfg_hit = frame_fall & idsel & (is_cfg_rd | is_cfg_wr) & (role == pci_hsk_pkg::ROLE_IDLE);
    // data phase completes only with both ready lines low
    wire init_xfer = (role == pci_hsk_pkg::ROLE_INIT) & ~irdy_n_out & ~trdy_n; // [R2]
    wire targ_xfer = (ts == pci_hsk_pkg::TS_DATA) & ~irdy_n; // [R2]
    // initiator wait state during a target transaction
    // the first data edge decides: ready still high there is taken as a wait
    wire targ_wait = (ts == pci_hsk_pkg::TS_DATA) & irdy_n; // [R1] [R9]

    // a configuration hit wins over a local start in the same cycle
    always_comb begin
        next_role = role;
        if (role == pci_hsk_pkg::ROLE_IDLE) begin
            if (cfg_hit) begin
                next_role = pci_hsk_pkg::ROLE_TARG;
            end else if (mst_start) begin
                next_role = pci_hsk_pkg::ROLE_INIT;
            end
        end else if (role == pci_hsk_pkg::ROLE_INIT) begin
            // stop seen low, or last word moved: end now
            if (~stop_n | (init_xfer & mst_last)) begin
                next_role = pci_hsk_pkg::ROLE_IDLE; // [R6] [R7]
            end
        end else if (ts == pci_hsk_pkg::TS_DONE) begin
            next_role = pci_hsk_pkg::ROLE_IDLE;
        end
    end

    always_comb begin
        next_ts = ts;
        unique case (ts)
            pci_hsk_pkg::TS_IDLE: begin
                if (cfg_hit) begin
                    next_ts = pci_hsk_pkg::TS_DATA; // [R12]
                end
            end
            pci_hsk_pkg::TS_DATA: begin
                if (targ_xfer | targ_wait) begin
                    next_ts = pci_hsk_pkg::TS_STOP; // [R8] [R9]
                end
            end
            // stop and device select stand until the host lets frame go high
            pci_hsk_pkg::TS_STOP: begin
                if (frame_n) begin
                    next_ts = pci_hsk_pkg::TS_DONE;
                end
            end
            pci_hsk_pkg::TS_DONE: begin
                next_ts = pci_hsk_pkg::TS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            role <= pci_hsk_pkg::ROLE_IDLE;
            ts <= pci_hsk_pkg::TS_IDLE;
            frame_q <= pci_hsk_pkg::RST_PIN;
            is_write <= 1'b0;
        end else begin
            role <= next_role;
            ts <= next_ts;
            frame_q <= frame_n;
            if (cfg_hit) begin
                is_write <= is_cfg_wr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers, all registered on the rising edge
    wire in_targ = (role == pci_hsk_pkg::ROLE_TARG);
    wire in_init = (role == pci_hsk_pkg::ROLE_INIT);
    wire targ_active = in_targ & (ts != pci_hsk_pkg::TS_DONE);
    // decoded next values of the pin drivers
    wire next_init = (next_role == pci_hsk_pkg::ROLE_INIT);
    wire next_targ = (next_role == pci_hsk_pkg::ROLE_TARG);
    wire next_idle = (next_role == pci_hsk_pkg::ROLE_IDLE);
    wire next_data = (next_ts == pci_hsk_pkg::TS_DATA);
    wire next_stop = (next_ts == pci_hsk_pkg::TS_STOP);
    // irdy: driven as initiator, input as target, floated otherwise
    wire next_irdy_n_oe = next_init; // [R3] [R4] [R5]
    wire next_irdy_n_out = ~(next_init & mst_ready); // [R1] [R5]
    // stop: output only as target, asserted only at disconnect
    wire next_stop_n_oe = next_targ; // [R10] [R11]
    wire next_stop_n_out = ~next_stop; // [R8] [R9] [R11]
    wire next_devsel_n_out = ~(next_data | next_stop); // [R12]
    wire next_trdy_n_out = ~next_data;
    wire next_mst_stopped = in_init & ~stop_n; // [R7]
    wire next_mst_done = in_init & next_idle;
    wire next_cfg_access = targ_active & targ_xfer; // [R2] [R8]

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irdy_n_out <= pci_hsk_pkg::RST_PIN;
            irdy_n_oe <= 1'b0;
            stop_n_out <= pci_hsk_pkg::RST_PIN;
            stop_n_oe <= 1'b0;
            devsel_n_out <= pci_hsk_pkg::RST_PIN;
            devsel_n_oe <= 1'b0;
            trdy_n_out <= pci_hsk_pkg::RST_PIN;
            trdy_n_oe <= 1'b0;
            mst_done <= 1'b0;
            mst_xfer <= 1'b0;
            mst_stopped <= 1'b0;
            cfg_access <= 1'b0;
            cfg_write <= 1'b0;
        end else begin
            irdy_n_oe <= next_irdy_n_oe;
            irdy_n_out <= next_irdy_n_out;
            stop_n_oe <= next_stop_n_oe;
            stop_n_out <= next_stop_n_out;
            devsel_n_oe <= next_targ;
            devsel_n_out <= next_devsel_n_out;
            trdy_n_oe <= next_targ;
            trdy_n_out <= next_trdy_n_out;
            mst_xfer <= init_xfer;
            mst_stopped <= next_mst_stopped;
            mst_done <= next_mst_done;
            cfg_access <= next_cfg_access;
            cfg_write <= is_write;
        end
    end
endmodule : pci_hsk_stop_cfg

// ---- tb/pci_hsk_stop_cfg_sva.sv ----
`timescale 1ns/1ps
module pci_hsk_stop_cfg_sva (
    input wire logic clock, arst_n, mst_ready, mst_done, cfg_access, frame_n_in, idsel_in,
    input wire logic stop_n_in, irdy_n_out, irdy_n_oe, stop_n_out, stop_n_oe,
    input wire logic devsel_n_out, devsel_n_oe,
    input wire logic [3:0] c_be_n_in
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire cfg_cmd = idsel_in && c_be_n_in[3:1] == 3'h5;
    cfg_claim_a: assert property ($fell(frame_n_in) && cfg_cmd |-> ##[2:8] !devsel_n_out)
        else $error("config hit not claimed");
    no_claim_a: assert property ($fell(frame_n_in) && !cfg_cmd |-> !devsel_n_oe [*8])
        else $error("foreign cycle claimed");
    stop_ends_a: assert property ($fell(stop_n_in) && irdy_n_oe |-> ##[1:8] !irdy_n_oe)
        else $error("initiator ignored stop");
    done_float_a: assert property (mst_done |-> ##[0:2] !irdy_n_oe)
        else $error("ready still driven after end");
    wait_high_a: assert property (!mst_ready ##1 (!mst_ready && irdy_n_oe) |-> irdy_n_out)
        else $error("ready low while master waits");
    one_role_a: assert property (!(irdy_n_oe && stop_n_oe))
        else $error("stop driven as initiator");
    stop_cause_a: assert property (stop_n_oe && !stop_n_out |-> devsel_n_oe && !devsel_n_out)
        else $error("stop outside target cycle");
    cfg_stop_a: assert property (cfg_access |-> ##[0:1] stop_n_oe && !stop_n_out)
        else $error("no disconnect after config word");
    cover property (cfg_access);
    cover property ($fell(stop_n_in) && irdy_n_oe);
    cover property (mst_done);
endmodule : pci_hsk_stop_cfg_sva
bind pci_hsk_stop_cfg pci_hsk_stop_cfg_sva pci_hsk_stop_cfg_sva_i (.*);

// ---- tb/pci_host_model.sv ----
`timescale 1ns/1ps
module pci_host_model (
    input wire logic clock, stop_req, slow, irdy_n_oe, stop_n_in,
    output logic frame_n_in, idsel_in, h_irdy, h_trdy, h_stop,
    output logic [3:0] c_be_n_in
);
    logic [1:0] phase = 2'h0;
    initial begin
        {frame_n_in, idsel_in, h_irdy, h_trdy, h_stop, c_be_n_in} = 9'h17f;
    end
    // target of the device's cycles: slow means ready two edges in four,
    // long enough to pass the device's pin filter
    always @(posedge clock) begin
        phase <= phase + 2'h1;
        h_trdy <= !(irdy_n_oe && !(slow && phase[1]));
        h_stop <= !(irdy_n_oe && stop_req);
    end
    task automatic cfg_cycle(input logic [3:0] cmd, input logic sel, input logic hold);
        int n;
        @(posedge clock);
        frame_n_in <= 1'b0;
        c_be_n_in <= cmd;
        idsel_in <= sel;
        // ready follows the address phase at once: the first data edge decides
        @(posedge clock);
        c_be_n_in <= 4'h0;
        h_irdy <= hold;
        for (n = 0; n < 12 && stop_n_in; n++) @(posedge clock);
        frame_n_in <= 1'b1;
        h_irdy <= 1'b0;
        idsel_in <= 1'b0;
        repeat (6) @(posedge clock);
        h_irdy <= 1'b1;
        c_be_n_in <= 4'hf;
        repeat (6) @(posedge clock);
    endtask : cfg_cycle
endmodule : pci_host_model

// ---- tb/pci_hsk_stop_cfg_bench.sv ----
`timescale 1ns/1ps
module pci_hsk_stop_cfg_bench;
    logic clock, arst_n, mst_start, mst_ready, mst_last, stop_req, slow, frame_n_in, idsel_in;
    logic mst_done, mst_xfer, mst_stopped, irdy_n_out, irdy_n_oe, stop_n_out, stop_n_oe;
    logic devsel_n_out, devsel_n_oe, trdy_n_out, trdy_n_oe, cfg_access, cfg_write;
    logic h_irdy, h_trdy, h_stop;
    logic [3:0] c_be_n_in;
    int bad_count = 0, checks = 0, cyc = 0, n_acc = 0, n_wr = 0, n_dev = 0, n_stop = 0;
    int n_xfer = 0, n_done = 0, n_halt = 0, n_trdy = 0;
    // pulled-up bus lines resolved from both parties
    wire irdy_n_in = irdy_n_oe ? irdy_n_out : h_irdy;
    wire trdy_n_in = trdy_n_oe ? trdy_n_out : h_trdy;
    wire stop_n_in = stop_n_oe ? stop_n_out : h_stop;
    pci_hsk_stop_cfg pci_hsk_stop_cfg_i (.*);
    pci_host_model pci_host_model_i (.*);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        n_acc <= n_acc + cfg_access;
        n_wr <= n_wr + (cfg_access && cfg_write);
        n_dev <= n_dev + (devsel_n_oe && !devsel_n_out);
        n_stop <= n_stop + (stop_n_oe && !stop_n_out);
        n_trdy <= n_trdy + (trdy_n_oe && !trdy_n_out);
        n_xfer <= n_xfer + mst_xfer;
        n_done <= n_done + mst_done;
        n_halt <= n_halt + mst_stopped;
        if (cyc == 3000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask : check
    task automatic conclude;
        $display("mismatches %0d, comparisons %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic t_cfg(input logic [3:0] cmd, input logic sel, input logic hold);
        int a, d, w, s, t;
        logic hit;
        a = n_acc;
        t = n_trdy;
        d = n_dev;
        w = n_wr;
        s = n_stop;
        hit = sel && (cmd == pci_hsk_pkg::CMD_CFG_READ || cmd == pci_hsk_pkg::CMD_CFG_WRITE);
        pci_host_model_i.cfg_cycle(cmd, sel, hold);
        check(n_dev > d, hit);
        check(n_stop > s, hit);
        check(n_trdy - t, hit);
        if (!hold) check(n_acc - a, hit);
        if (!hold) check(n_wr - w, hit && cmd == pci_hsk_pkg::CMD_CFG_WRITE);
    endtask : t_cfg
    task automatic t_master(input logic halt);
        int x, dn, h, n;
        x = n_xfer;
        dn = n_done;
        h = n_halt;
        stop_req <= halt;
        slow <= 1'b1;
        mst_last <= !halt;
        mst_ready <= 1'b0;
        mst_start <= 1'b1;
        for (n = 0; n < 20 && !irdy_n_oe; n++) @(posedge clock);
        mst_start <= 1'b0;
        repeat (4) @(posedge clock);
        mst_ready <= 1'b1;
        for (n = 0; n < 60 && n_done == dn; n++) @(posedge clock);
        repeat (2) @(posedge clock);
        check(n_done - dn, 1);
        check(n_halt - h, halt);
        if (!halt) check(n_xfer - x, 1);
        stop_req <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : t_master
    initial begin
        {arst_n, mst_start, mst_ready, mst_last, stop_req, slow} = 6'h00;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        repeat (6) @(posedge clock);
        t_cfg(pci_hsk_pkg::CMD_CFG_READ, 1'b1, 1'b0);
        t_cfg(pci_hsk_pkg::CMD_CFG_WRITE, 1'b1, 1'b0);
        t_cfg(4'h6, 1'b1, 1'b0);
        t_cfg(pci_hsk_pkg::CMD_CFG_READ, 1'b0, 1'b0);
        t_cfg(pci_hsk_pkg::CMD_CFG_WRITE, 1'b1, 1'b1);
        t_master(1'b0);
        t_master(1'b1);
        conclude();
    end
endmodule : pci_hsk_stop_cfg_bench
